// *** logic/afst_pkg.sv ***
package afst_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_POWER = 8'h08;
	localparam logic [7:0] REG_TEST_MODE = 8'h0d;
	localparam logic [7:0] REG_SELF_TEST = 8'h0e;
	localparam logic [7:0] REG_OUT_MODE = 8'h14;
	localparam logic [7:0] REG_SIG_LOW = 8'h24;
	localparam logic [7:0] REG_SIG_HIGH = 8'h25;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int PW_MODE_LSB = 0;
	localparam int PW_DITHER = 4;
	localparam int PW_PIN_STBY = 5;
	localparam int TM_SEL_LSB = 0;
	localparam int TM_HOLD_LONG = 4;
	localparam int TM_HOLD_SHORT = 5;
	localparam int ST_ENABLE = 0;
	localparam int ST_RESTART = 2;
	localparam int OM_FMT_LSB = 0;
	localparam int OM_DISABLE = 2;
	localparam int OM_DCO_INV = 3;
	localparam int OM_LVDS = 4;
	localparam int OM_SWING = 5;
	// ****************************************
	// Datapath and timing
	// ****************************************
	localparam int DATA_W = 14;
	localparam int LANE_W = 7;
	localparam int LAT_CYC = 12;
	localparam int SELF_TEST_CYC = 512;
	localparam int SELF_TEST_CNT_W = 10;
	localparam int SIG_W = 16;
	localparam logic [15:0] SIG_SEED = 16'h0000;
	localparam logic [22:0] PNL_SEED = 23'h7fffff;
	localparam logic [8:0] PNS_SEED = 9'h1ff;
	localparam logic [13:0] PAT_MID = 14'h2000;
	localparam logic [13:0] PAT_PFS = 14'h3fff;
	localparam logic [13:0] PAT_NFS = 14'h0000;
	localparam logic [13:0] PAT_CHK = 14'h1555;
	typedef enum logic [1:0] {
		FMT_OFFSET = 2'h0,
		FMT_TWOS = 2'h1,
		FMT_GRAY = 2'h2
	} afst_fmt_t;
	typedef enum logic [1:0] {
		PM_NORMAL = 2'h0,
		PM_DOWN = 2'h1,
		PM_STBY = 2'h2
	} afst_pm_t;
	typedef enum logic [3:0] {
		TP_OFF = 4'h0,
		TP_MID = 4'h1,
		TP_PFS = 4'h2,
		TP_NFS = 4'h3,
		TP_CHK = 4'h4,
		TP_PN_LONG = 4'h5,
		TP_PN_SHORT = 4'h6,
		TP_TOGGLE = 4'h7
	} afst_tp_t;
	typedef enum logic [1:0] {
		BS_IDLE = 2'b01,
		BS_RUN = 2'b10
	} afst_self_test_t;
endpackage

// *** logic/afst_pn_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface afst_pn_if;
	logic step;
	logic restart;
	logic hold_long;
	logic hold_short;
	logic [13:0] word_long;
	logic [13:0] word_short;
	modport gen (input step, restart, hold_long, hold_short, output word_long, word_short);
	modport user (output step, restart, hold_long, hold_short, input word_long, word_short);
endinterface
`default_nettype wire

// *** logic/afst_pn.sv ***
`timescale 1ns/1ns
`default_nettype none
module afst_pn (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Generator control and words
	afst_pn_if.gen pn
);
	import afst_pkg::*;
	logic [22:0] long_q;
	logic [22:0] long_d;
	logic [8:0] short_q;
	logic [8:0] short_d;
	// ****************************************
	// Generators
	// ****************************************
	// Seed hold beats stepping so the seed is parked while the bit stays set
	assign long_d = pn.hold_long ? PNL_SEED :
		pn.step ? {long_q[21:0], long_q[22] ^ long_q[17]} : long_q;
	assign short_d = (pn.hold_short || pn.restart) ? PNS_SEED :
		pn.step ? {short_q[7:0], short_q[8] ^ short_q[4]} : short_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			long_q <= PNL_SEED;
			short_q <= PNS_SEED;
		end else begin
			long_q <= long_d;
			short_q <= short_d;
		end
	end
	assign pn.word_long = long_q[13:0];
	assign pn.word_short = {short_q, short_q[8:4]};
endmodule
`default_nettype wire

// *** logic/afst_core.sv ***
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Power-down stops conversion, outputs high impedance
// - Standby keeps reference on; pin role selectable
// - CMOS by default; LVDS by pin or register
// - Reduced LVDS swing by pin or register
// - Format pin selects offset binary or twos
// - Serial mode offers offset, twos, gray
// - Output-disable pin three-states data and clock
// - Output-disable register bit three-states outputs too
// - Pin and register bit are ORed
// - Latency 12 cycles CMOS; LVDS even lanes at 11.5, odd lanes at 12
// - Data updates after sample clock rising edge
// - CMOS data clock, capture rising, invertible
// - LVDS double rate, odd rise, even fall
// - Offset codes, twos flips top, overrange flag
// - Self-test drives pseudorandom words 512 cycles
// - Signature stored in two read-only registers
// - Outputs stay connected during self-test
// - Control bit restarts or continues generator
// - Test mode replaces core, goes through formatter
// - Reset bits hold generators at seed
// - Patterns advance only on sample clock
module afst_core #(
	parameter int LATENCY = afst_pkg::LAT_CYC,
	parameter int SELF_TEST_LEN = afst_pkg::SELF_TEST_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sample clock and converter core
	input wire logic sample_clk,
	input wire logic [afst_pkg::DATA_W-1:0] core_code,
	input wire logic core_over,
	// Static control pins
	input wire logic serial_mode_pin,
	input wire logic power_down_pin,
	input wire logic output_disable_pin,
	input wire logic lvds_select_pin,
	input wire logic reduced_swing_select,
	input wire logic format_select_pin,
	input wire logic dither_pin,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [afst_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// Output pins
	output logic [afst_pkg::DATA_W-1:0] data_q,
	output logic data_oe_n_q,
	output logic over_q,
	output logic data_clock_output_q,
	output logic dco_oe_n_q,
	// Analog controls
	output logic lvds_mode_q,
	output logic reduced_swing_q,
	output logic dither_q,
	output logic ref_on_q,
	output logic core_on_q
);
	import afst_pkg::*;
	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] c, input logic [1:0] f);
		logic [DATA_W-1:0] r;
		r = c;
		if (f == FMT_TWOS) begin
			r = {~c[DATA_W-1], c[DATA_W-2:0]};
		end else if (f == FMT_GRAY) begin
			r = c ^ (c >> 1);
		end
		return r;
	endfunction
	function automatic logic [LANE_W-1:0] lanes(input logic [DATA_W-1:0] w, input logic odd);
		logic [LANE_W-1:0] r;
		r = '0;
		for (int i = 0; i < LANE_W; i++) begin
			r[i] = odd ? w[2*i+1] : w[2*i];
		end
		return r;
	endfunction
	function automatic logic [SIG_W-1:0] misr(input logic [SIG_W-1:0] s, input logic [DATA_W:0] w);
		return {s[SIG_W-2:0], s[15] ^ s[14] ^ s[12] ^ s[3]} ^ {{(SIG_W-DATA_W-1){1'b0}}, w};
	endfunction
	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NSYNC = 8 + DATA_W + 1;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic sclk3_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sclk3_q <= 1'b0;
		end else begin
			sync1_q <= {sample_clk, serial_mode_pin, power_down_pin, output_disable_pin,
				lvds_select_pin, reduced_swing_select, format_select_pin, dither_pin,
				core_over, core_code};
			sync2_q <= sync1_q;
			sclk3_q <= sync2_q[NSYNC-1];
		end
	end
	wire sclk_s = sync2_q[NSYNC-1];
	wire serial_s = sync2_q[NSYNC-2];
	wire pd_pin_s = sync2_q[NSYNC-3];
	wire dis_pin_s = sync2_q[NSYNC-4];
	wire lvds_pin_s = sync2_q[NSYNC-5];
	wire rs_pin_s = sync2_q[NSYNC-6];
	wire fmt_pin_s = sync2_q[NSYNC-7];
	wire dith_pin_s = sync2_q[NSYNC-8];
	wire [DATA_W:0] core_s = sync2_q[DATA_W:0];
	wire samp_rise = sclk_s & ~sclk3_q;
	wire samp_fall = ~sclk_s & sclk3_q;
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] pwr_q;
	logic [7:0] tm_q;
	logic [7:0] st_q;
	logic [7:0] om_q;
	logic [SIG_W-1:0] sig_q;
	afst_self_test_t bs_q;
	logic [SELF_TEST_CNT_W-1:0] bcnt_q;
	logic [SIG_W-1:0] misr_q;
	wire wr_pwr = reg_wr && reg_addr == REG_POWER;
	wire wr_tm = reg_wr && reg_addr == REG_TEST_MODE;
	wire wr_st = reg_wr && reg_addr == REG_SELF_TEST;
	wire wr_om = reg_wr && reg_addr == REG_OUT_MODE;
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (reg_addr == REG_POWER) begin
			rd_mux = pwr_q;
		end else if (reg_addr == REG_TEST_MODE) begin
			rd_mux = tm_q;
		end else if (reg_addr == REG_SELF_TEST) begin
			rd_mux = st_q;
		end else if (reg_addr == REG_OUT_MODE) begin
			rd_mux = om_q;
		end else if (reg_addr == REG_SIG_LOW) begin
			rd_mux = sig_q[7:0];
		end else if (reg_addr == REG_SIG_HIGH) begin
			rd_mux = sig_q[15:8];
		end
	end
	// ****************************************
	// Effective controls
	// ****************************************
	wire [1:0] pm_reg = pwr_q[PW_MODE_LSB +: 2];
	wire pin_stby = pwr_q[PW_PIN_STBY];
	wire pd_eff = pm_reg == PM_DOWN || (pd_pin_s && !pin_stby);
	wire stby_eff = pm_reg == PM_STBY || (pd_pin_s && pin_stby);
	wire convert = !pd_eff && !stby_eff;
	wire dis_eff = dis_pin_s | om_q[OM_DISABLE];
	wire lvds_eff = lvds_pin_s | om_q[OM_LVDS];
	wire rs_eff = rs_pin_s | om_q[OM_SWING];
	wire dith_eff = dith_pin_s | pwr_q[PW_DITHER];
	// Pin strap only picks between two codes; gray needs the serial port
	wire [1:0] fmt_sel = serial_s ? om_q[OM_FMT_LSB +: 2] : {1'b0, fmt_pin_s};
	wire drive = convert && !dis_eff;
	wire step = samp_rise && convert;
	// ****************************************
	// Pattern generators and self-test
	// ****************************************
	afst_pn_if pn_if ();
	afst_pn u_pn (
		.clk(clk),
		.rst(rst),
		.pn(pn_if.gen)
	);
	wire self_test_start = wr_st && reg_wdata[ST_ENABLE] && bs_q == BS_IDLE;
	wire self_test_run = bs_q == BS_RUN;
	wire self_test_last = self_test_run && step && bcnt_q == SELF_TEST_CNT_W'(SELF_TEST_LEN - 1);
	assign pn_if.step = step;
	assign pn_if.restart = self_test_start && reg_wdata[ST_RESTART];
	assign pn_if.hold_long = tm_q[TM_HOLD_LONG];
	assign pn_if.hold_short = tm_q[TM_HOLD_SHORT];
	wire [3:0] tp_sel = tm_q[TM_SEL_LSB +: 4];
	logic toggle_q;
	logic [DATA_W:0] src;
	always_comb begin
		src = core_s;
		if (tp_sel == TP_MID) begin
			src = {1'b0, PAT_MID};
		end else if (tp_sel == TP_PFS) begin
			src = {1'b0, PAT_PFS};
		end else if (tp_sel == TP_NFS) begin
			src = {1'b0, PAT_NFS};
		end else if (tp_sel == TP_CHK) begin
			src = {1'b0, toggle_q ? ~PAT_CHK : PAT_CHK};
		end else if (tp_sel == TP_PN_LONG) begin
			src = {1'b0, pn_if.word_long};
		end else if (tp_sel == TP_PN_SHORT) begin
			src = {1'b0, pn_if.word_short};
		end else if (tp_sel == TP_TOGGLE) begin
			src = {1'b0, toggle_q ? PAT_PFS : PAT_NFS};
		end else if (self_test_run) begin
			src = {1'b0, pn_if.word_short};
		end
	end
	// Core already clamps; overrange rides beside the code
	wire [DATA_W:0] fword = {src[DATA_W], fmt_word(src[DATA_W-1:0], fmt_sel)};
	wire [SIG_W-1:0] misr_d = misr(misr_q, fword);
	// ****************************************
	// Register and self-test state
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_q <= REG_RESET_VAL;
			tm_q <= REG_RESET_VAL;
			om_q <= REG_RESET_VAL;
			st_q <= REG_RESET_VAL;
			sig_q <= SIG_SEED;
			misr_q <= SIG_SEED;
			bcnt_q <= '0;
			bs_q <= BS_IDLE;
			toggle_q <= 1'b0;
		end else begin
			if (wr_pwr) pwr_q <= reg_wdata;
			if (wr_tm) tm_q <= reg_wdata;
			if (wr_om) om_q <= reg_wdata;
			if (step) toggle_q <= ~toggle_q;
			case (bs_q)
				BS_IDLE: begin
					if (wr_st) st_q <= reg_wdata;
					if (self_test_start) begin
						bs_q <= BS_RUN;
						bcnt_q <= '0;
						misr_q <= SIG_SEED;
					end
				end
				BS_RUN: begin
					if (step) begin
						bcnt_q <= bcnt_q + 1'b1;
						misr_q <= misr_d;
					end
					if (self_test_last) begin
						bs_q <= BS_IDLE;
						sig_q <= misr_d;
						st_q[ST_ENABLE] <= 1'b0;
					end
				end
				default: bs_q <= BS_IDLE;
			endcase
		end
	end
	// ****************************************
	// Pipeline and output stage
	// ****************************************
	logic [DATA_W:0] pipe_q [LATENCY];
	logic [DATA_W:0] hold_q;
	// Cleared on reset so no unknown word reaches the pins or the checks
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < LATENCY; i++) begin
				pipe_q[i] <= '0;
			end
		end else if (step) begin
			pipe_q[0] <= fword;
			for (int i = 1; i < LATENCY; i++) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end
	wire [DATA_W:0] tail = pipe_q[LATENCY-1];
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q <= '0;
			data_q <= '0;
			over_q <= 1'b0;
			data_clock_output_q <= 1'b0;
			data_oe_n_q <= 1'b1;
			dco_oe_n_q <= 1'b1;
		end else begin
			data_oe_n_q <= !drive;
			dco_oe_n_q <= !drive;
			if (lvds_eff) begin
				data_clock_output_q <= sclk_s;
				if (samp_fall && convert) begin
					hold_q <= tail;
					data_q <= {{(DATA_W-LANE_W){1'b0}}, lanes(tail[DATA_W-1:0], 1'b0)};
					over_q <= tail[DATA_W];
				end else if (step) begin
					data_q <= {{(DATA_W-LANE_W){1'b0}}, lanes(hold_q[DATA_W-1:0], 1'b1)};
				end
			end else begin
				// Rising edge sits mid-word so capture has half a period of margin
				data_clock_output_q <= ~sclk_s ^ om_q[OM_DCO_INV];
				if (step) begin
					data_q <= tail[DATA_W-1:0];
					over_q <= tail[DATA_W];
				end
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_q <= '0;
			reg_rvalid_q <= 1'b0;
			lvds_mode_q <= 1'b0;
			reduced_swing_q <= 1'b0;
			dither_q <= 1'b0;
			ref_on_q <= 1'b0;
			core_on_q <= 1'b0;
		end else begin
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
			reg_rvalid_q <= reg_rd;
			lvds_mode_q <= lvds_eff;
			reduced_swing_q <= lvds_eff && rs_eff;
			dither_q <= dith_eff;
			ref_on_q <= !pd_eff;
			core_on_q <= convert;
		end
	end
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [SELF_TEST_CNT_W:0] h_steps_q;
	always_ff @(posedge clk) begin
		if (rst || self_test_start) h_steps_q <= '0;
		else if (self_test_run && step) h_steps_q <= h_steps_q + 1'b1;
	end
	a_pd_hiz_out: assert property (pd_eff |=> data_oe_n_q && !core_on_q)
		else $error("power-down left outputs driven");
	a_stby_ref_on: assert property (stby_eff && !pd_eff |=> ref_on_q && !core_on_q)
		else $error("standby lost reference");
	a_lvds_pin_sel: assert property (lvds_pin_s |=> lvds_mode_q)
		else $error("lvds pin ignored");
	a_swing_sel: assert property (lvds_eff && rs_pin_s |=> reduced_swing_q)
		else $error("reduced swing not selected");
	a_disable_hiz: assert property (dis_eff |=> data_oe_n_q && dco_oe_n_q)
		else $error("disable left outputs driven");
	a_cmos_latency: assert property (step && !lvds_eff |=> data_q == $past(tail[DATA_W-1:0]))
		else $error("cmos word not from pipeline tail");
	a_self_test_length: assert property ($fell(self_test_run) |-> h_steps_q == (SELF_TEST_CNT_W+1)'(SELF_TEST_LEN))
		else $error("self-test length wrong");
	a_sig_stored: assert property (self_test_last |=> sig_q == $past(misr_d) && bs_q == BS_IDLE)
		else $error("signature not stored");
	a_seed_hold: assert property (tm_q[TM_HOLD_SHORT] [*2] |-> pn_if.word_short == {PNS_SEED, PNS_SEED[8:4]})
		else $error("short generator not at seed");
	a_twos_top: assert property (fmt_sel == FMT_TWOS |-> fword[DATA_W-1] == ~src[DATA_W-1])
		else $error("twos top bit not inverted");
	c_self_test_done: cover property (self_test_last);
	c_lvds_fall: cover property (lvds_eff && samp_fall && convert);
	c_power_down: cover property ($rose(pd_eff));
	c_pattern_run: cover property (tp_sel == TP_PN_LONG && step);
endmodule
`default_nettype wire

// *** verif/afst_capture.sv ***
`timescale 1ns/1ns
`default_nettype none
module afst_capture (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Converter outputs
	input wire logic [afst_pkg::DATA_W-1:0] data,
	input wire logic data_clock_output,
	input wire logic dco_oe_n,
	input wire logic lvds,
	// Captured values
	output logic [afst_pkg::DATA_W-1:0] word_q,
	output logic [afst_pkg::LANE_W-1:0] rise_lane_q,
	output logic [afst_pkg::LANE_W-1:0] fall_lane_q
);
	import afst_pkg::*;
	// ****************************************
	// Capture register
	// ****************************************
	logic dco_q;
	logic rise;
	logic fall;
	assign rise = data_clock_output && !dco_q;
	assign fall = !data_clock_output && dco_q;
	// Edges found in the clk domain, so no race with the launch edge
	always_ff @(posedge clk) begin
		dco_q <= data_clock_output;
		if (rst) begin
			word_q <= '0;
			rise_lane_q <= '0;
			fall_lane_q <= '0;
		end else if (!dco_oe_n) begin
			if (rise && !lvds) word_q <= data;
			if (rise && lvds) rise_lane_q <= data[LANE_W-1:0];
			if (fall && lvds) fall_lane_q <= data[LANE_W-1:0];
		end
	end
endmodule
`default_nettype wire

// *** verif/afst_core_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module afst_core_bench;
	import afst_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	localparam int LAT = 4;
	localparam int BLEN = 16;
	logic clk, rst, sample_clk, run_s, core_over, serial_mode_pin, power_down_pin;
	logic output_disable_pin, lvds_select_pin, reduced_swing_select, format_select_pin;
	logic dither_pin, reg_wr, reg_rd, reg_rvalid_q, over_q, data_oe_n_q, dco_q, dco_oe_n_q;
	logic lvds_mode_q, reduced_swing_q, dither_q, ref_on_q, core_on_q;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
	logic [13:0] core_code, data_q, cap_word, base, exp, w;
	logic [6:0] rl, fl;
	logic [15:0] s1, s2, s3;
	int mismatches, num_checks, nrise;
	afst_core #(.LATENCY(LAT), .SELF_TEST_LEN(BLEN)) i_dut (.clk(clk), .rst(rst),
		.sample_clk(sample_clk), .core_code(core_code), .core_over(core_over),
		.serial_mode_pin(serial_mode_pin), .power_down_pin(power_down_pin),
		.output_disable_pin(output_disable_pin), .lvds_select_pin(lvds_select_pin),
		.reduced_swing_select(reduced_swing_select), .format_select_pin(format_select_pin),
		.dither_pin(dither_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
		.data_q(data_q), .data_oe_n_q(data_oe_n_q), .over_q(over_q),
		.data_clock_output_q(dco_q), .dco_oe_n_q(dco_oe_n_q), .lvds_mode_q(lvds_mode_q),
		.reduced_swing_q(reduced_swing_q), .dither_q(dither_q), .ref_on_q(ref_on_q),
		.core_on_q(core_on_q));
	afst_capture i_cap (.clk(clk), .rst(rst), .data(data_q), .data_clock_output(dco_q),
		.dco_oe_n(dco_oe_n_q), .lvds(lvds_mode_q), .word_q(cap_word), .rise_lane_q(rl),
		.fall_lane_q(fl));
	// ****************************************
	// Clocks and tasks
	// ****************************************
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// Sample clock may be stopped, so it holds its level while halted
	initial begin
		sample_clk = 0;
		#7;
		forever #40 if (run_s) sample_clk = ~sample_clk;
	end
	always @(posedge sample_clk) nrise++;
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task rises(input int n);
		int t0;
		t0 = nrise;
		for (int t = 0; t < n * 30 && nrise < t0 + n; t++) @(negedge clk);
		if (nrise < t0 + n) begin
			mismatches++;
			summarize();
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_rd = 1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 0;
		`CHK(reg_rvalid_q, 1'b1);
		d = reg_rdata_q;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		`CHK(v, e);
	endtask
	// Order: data oe_n, dco oe_n, lvds, swing, dither, ref, core
	task st(input logic [6:0] e);
		repeat (8) @(negedge clk);
		`CHK({data_oe_n_q, dco_oe_n_q, lvds_mode_q, reduced_swing_q, dither_q, ref_on_q,
			core_on_q}, e);
	endtask
	task self_test(input logic [7:0] c, output logic [15:0] s);
		wr(REG_SELF_TEST, c);
		rises(LAT + 1);
		w = data_q;
		rises(1);
		`CHK(data_q !== w, 1'b1);
		`CHK(data_oe_n_q, 1'b0);
		rises(BLEN + 4);
		rchk(REG_SELF_TEST, c & 8'h04);
		rd(REG_SIG_LOW, s[7:0]);
		rd(REG_SIG_HIGH, s[15:8]);
	endtask
	initial begin
		#300000;
		mismatches++;
		summarize();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{rst, run_s, serial_mode_pin} = 3'b111;
		{core_over, power_down_pin, output_disable_pin, lvds_select_pin} = 4'h0;
		{reduced_swing_select, format_select_pin, dither_pin, reg_wr, reg_rd} = 5'h00;
		{reg_addr, reg_wdata, core_code} = '0;
		repeat (6) @(negedge clk);
		`CHK({data_oe_n_q, dco_oe_n_q}, 2'b11);
		rst = 0;
		st(7'b0000011);
		rchk(REG_TEST_MODE, 8'h00);
		rchk(REG_SELF_TEST, 8'h00);
		rchk(REG_OUT_MODE, 8'h00);
		rchk(REG_SIG_HIGH, 8'h00);
		wr(REG_OUT_MODE, 8'h2a);
		rchk(REG_OUT_MODE, 8'h2a);
		wr(8'h30, 8'h5a);
		rchk(8'h30, 8'h00);
		wr(REG_SIG_LOW, 8'hff);
		rchk(REG_SIG_LOW, 8'h00);
		output_disable_pin = 1;
		st(7'b1100011);
		output_disable_pin = 0;
		wr(REG_OUT_MODE, 8'h04);
		st(7'b1100011);
		wr(REG_OUT_MODE, 8'h00);
		power_down_pin = 1;
		st(7'b1100000);
		power_down_pin = 0;
		st(7'b0000011);
		wr(REG_POWER, 8'h01);
		st(7'b1100000);
		wr(REG_POWER, 8'h02);
		st(7'b1100010);
		wr(REG_POWER, 8'h20);
		power_down_pin = 1;
		st(7'b1100010);
		power_down_pin = 0;
		wr(REG_POWER, 8'h10);
		st(7'b0000111);
		wr(REG_POWER, 8'h00);
		dither_pin = 1;
		st(7'b0000111);
		{dither_pin, lvds_select_pin, reduced_swing_select} = 3'b011;
		st(7'b0011011);
		{lvds_select_pin, reduced_swing_select} = 2'b00;
		wr(REG_OUT_MODE, 8'h30);
		st(7'b0011011);
		// Every fixed pattern through every code format
		for (int p = 1; p <= 3; p++) begin
			for (int f = 0; f < 3; f++) begin
				wr(REG_TEST_MODE, 8'(p));
				wr(REG_OUT_MODE, 8'(f));
				rises(LAT + 4);
				base = (p == 1) ? PAT_MID : (p == 2) ? PAT_PFS : PAT_NFS;
				exp = (f == 1) ? base ^ 14'h2000 : (f == 2) ? base ^ (base >> 1) : base;
				`CHK(cap_word, exp);
			end
		end
		wr(REG_TEST_MODE, 8'h00);
		wr(REG_OUT_MODE, 8'h00);
		{serial_mode_pin, format_select_pin, core_over} = 3'b011;
		core_code = 14'h1234;
		rises(LAT + 4);
		`CHK(cap_word, 14'h3234);
		`CHK(over_q, 1'b1);
		{format_select_pin, core_over} = 2'b00;
		rises(LAT + 4);
		`CHK(cap_word, 14'h1234);
		`CHK(over_q, 1'b0);
		// New code stands from just after one rise, so that rise takes it
		core_code = 14'h0abc;
		rises(LAT + 4);
		core_code = 14'h0123;
		rises(LAT - 1);
		repeat (8) @(negedge clk);
		`CHK(data_q, 14'h0abc);
		rises(1);
		repeat (8) @(negedge clk);
		`CHK(data_q, 14'h0123);
		`CHK(dco_q, 1'b0);
		wr(REG_OUT_MODE, 8'h08);
		rises(1);
		repeat (8) @(negedge clk);
		`CHK(dco_q, 1'b1);
		wr(REG_OUT_MODE, 8'h00);
		serial_mode_pin = 1;
		wr(REG_TEST_MODE, 8'h01);
		lvds_select_pin = 1;
		rises(LAT + 4);
		`CHK(rl, 7'h40);
		`CHK(rl & fl, 7'h00);
		`CHK(data_q[13:7], 7'h00);
		lvds_select_pin = 0;
		wr(REG_TEST_MODE, 8'h26);
		rises(LAT + 4);
		`CHK(data_q, 14'h3fff);
		wr(REG_TEST_MODE, 8'h15);
		rises(LAT + 4);
		`CHK(data_q, 14'h3fff);
		wr(REG_TEST_MODE, 8'h06);
		rises(LAT + 4);
		run_s = 0;
		repeat (10) @(negedge clk);
		w = data_q;
		repeat (60) @(negedge clk);
		`CHK(data_q, w);
		run_s = 1;
		rises(2);
		`CHK(data_q !== w, 1'b1);
		wr(REG_TEST_MODE, 8'h00);
		self_test(8'h05, s1);
		self_test(8'h05, s2);
		`CHK(s2, s1);
		self_test(8'h01, s3);
		`CHK(s3 !== s1, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
